// ---- srap_pkg.sv ----
// Purpose: shared constants and types of the serial register access port
// Assumes: ref_clk at 40 MHz
// Notes:   sync vector index map below is used by srap_top
`default_nettype none
package srap_pkg;
  localparam int CLK_KHZ     = 40000;
  localparam int TIMEOUT_US  = 32800;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_KHZ / 1000;
  localparam int DATA_W      = 16;
  localparam int PTR_W       = 8;
  localparam int FRAME_W     = 24;
  localparam int RW_BIT      = 23;
  localparam int ADR_HI      = 22;
  localparam int ADR_LO      = 16;
  localparam int NSYNC       = 9;
  localparam int I_SCL       = 0;
  localparam int I_SDA       = 1;
  localparam int I_CS        = 2;
  localparam int I_SCLK      = 3;
  localparam int I_SDI       = 4;
  localparam int I_SEL       = 5;
  localparam int I_A0        = 6;
  localparam int I_A1        = 7;
  localparam int I_A2        = 8;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] TX_LAST    = 4'h7;
  localparam logic [2:0] STRAP_WAIT = 3'h7;
  localparam logic [0:7][6:0] TADDR = {7'h61, 7'h2c, 7'h64, 7'h2e,
                                       7'h62, 7'h2d, 7'h65, 7'h2f};
  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_ADDR = 3'b001,
    I_ACK  = 3'b010,
    I_RX   = 3'b011,
    I_TX   = 3'b100,
    I_MACK = 3'b101
  } srap_i2c_st_t;
  typedef enum logic [1:0] {
    PH_PTR = 2'b00,
    PH_HI  = 2'b01,
    PH_LO  = 2'b10
  } srap_wph_t;
endpackage : srap_pkg
`default_nettype wire

// ---- srap_top.sv ----
// Purpose: serial register access port, i2c target or 24-bit spi target
// Assumes: bank returns reg_rdata in the cycle after reg_rd
// Notes:   scl high must last a few ref_clk cycles; hs-mode speed not reached
//
// Operation
// - an 8-bit pointer selects the 16-bit register for i2c data
// - upper byte moves first, then lower byte
// - i2c write buffers upper byte, commits word on lower byte
// - i2c read snapshots word at upper byte, lower byte from snapshot
// - pointer never auto-increments
// - pointer-only write without data is accepted
// - line low 32.8 ms inside a transaction resets the i2c side
// - single write: address, pointer, upper, lower; every byte acknowledged
// - after each word another pointer and word may follow
// - read: pointer write, repeated start, read address, upper then lower
// - nack on lower byte then stop ends the read, sda released
// - ack on lower byte restarts upper/lower pair from the pointer
// - spi frame: bit 23 direction, 22..16 address, 15..0 data
// - bit 23 low writes data, high requests a read
// - sdi shifts msb first on falling sclk while chip select low
// - chip select high: sclk and sdi ignored, sdo released
// - chip select rising edge decodes frame and moves data
// - read data leaves on sdo bits 15..0 in the next frame
// - strap low selects i2c, strap high selects spi
// - 7-bit target address from three straps, no general call
`timescale 1ns/10ps
`default_nettype none
module srap_top #(
  parameter int TIMEOUT_CYC = srap_pkg::TIMEOUT_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        if_sel_strap,
  input  wire logic        target_addr_strap_0,
  input  wire logic        target_addr_strap_1,
  input  wire logic        target_addr_strap_2,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_sclk,
  input  wire logic        spi_sdi,
  output logic             spi_sdo,
  output logic             spi_sdo_oe_n,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [7:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  localparam int TO_W = $clog2(TIMEOUT_CYC + 1);
  localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYC - 1);
  localparam int NS = srap_pkg::NSYNC;
  localparam int FW = srap_pkg::FRAME_W;
  localparam int DW = srap_pkg::DATA_W;

  typedef struct packed {
    logic [NS-1:0]         s1;
    logic [NS-1:0]         s2;
    logic [NS-1:0]         s3;
    logic [NS-1:0]         f;
    logic [2:0]            strap_cnt;
    logic                  spi;
    logic [6:0]            taddr;
    srap_pkg::srap_i2c_st_t st;
    srap_pkg::srap_wph_t   ph;
    logic [3:0]            bits;
    logic [7:0]            sh;
    logic                  rw;
    logic                  txlo;
    logic [7:0]            ptr;
    logic [7:0]            hibuf;
    logic [DW-1:0]         snap;
    logic [TO_W-1:0]       to;
    logic                  sda_rel;
    logic [FW-1:0]         sin;
    logic [FW-1:0]         sout;
    logic                  prev_rd;
    logic                  wr;
    logic                  rd;
    logic                  rdp;
    logic [7:0]            addr;
    logic [DW-1:0]         wdata;
  } srap_state_t;

  // sync stages reset high so chip select looks idle and no edge is faked
  localparam srap_state_t Q_RST = '{s1: '1, s2: '1, s3: '1, f: '1,
                                    st: srap_pkg::I_IDLE, ph: srap_pkg::PH_PTR,
                                    sda_rel: 1'b1, default: '0};

  srap_state_t   q;
  srap_state_t   n;
  logic [NS-1:0] sync_in;
  logic [NS-1:0] f_nx;
  logic          ready;
  logic          scl_r;
  logic          scl_f;
  logic          i_start;
  logic          i_stop;
  logic          cs_fall;
  logic          cs_rise;
  logic          sclk_f;
  logic          sda_now;

  assign sync_in = {target_addr_strap_2, target_addr_strap_1, target_addr_strap_0,
                    if_sel_strap, spi_sdi, spi_sclk, spi_cs_n, sda_in, scl_in};

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_flt
      // a change counts only once the last two stages agree
      assign f_nx[gi] = (q.s2[gi] == q.s3[gi]) ? q.s3[gi] : q.f[gi];
    end
  endgenerate

  assign ready   = (q.strap_cnt == srap_pkg::STRAP_WAIT);
  assign sda_now = f_nx[srap_pkg::I_SDA];
  assign scl_r   = f_nx[srap_pkg::I_SCL] & ~q.f[srap_pkg::I_SCL];
  assign scl_f   = ~f_nx[srap_pkg::I_SCL] & q.f[srap_pkg::I_SCL];
  assign i_start = q.f[srap_pkg::I_SCL] & f_nx[srap_pkg::I_SCL]
                   & q.f[srap_pkg::I_SDA] & ~sda_now;
  assign i_stop  = q.f[srap_pkg::I_SCL] & f_nx[srap_pkg::I_SCL]
                   & ~q.f[srap_pkg::I_SDA] & sda_now;
  assign cs_fall = q.f[srap_pkg::I_CS] & ~f_nx[srap_pkg::I_CS];
  assign cs_rise = ~q.f[srap_pkg::I_CS] & f_nx[srap_pkg::I_CS];
  assign sclk_f  = q.f[srap_pkg::I_SCLK] & ~f_nx[srap_pkg::I_SCLK];

  always_comb begin
    n       = q;
    n.s1    = sync_in;
    n.s2    = q.s1;
    n.s3    = q.s2;
    n.f     = f_nx;
    n.wr    = 1'b0;
    n.rd    = 1'b0;
    n.rdp   = q.rd;
    if (q.rdp) begin
      n.snap = reg_rdata;
    end
    if (!ready) begin
      // straps are sampled every cycle until ready; the last sample, taken after the synchronisers have settled, is kept
      n.strap_cnt = q.strap_cnt + 3'h1;
      n.spi       = q.f[srap_pkg::I_SEL];
      n.taddr     = srap_pkg::TADDR[{q.f[srap_pkg::I_A0], q.f[srap_pkg::I_A1],
                                     q.f[srap_pkg::I_A2]}];
    end else if (!q.spi) begin
      if (i_start) begin
        n.st      = srap_pkg::I_ADDR;
        n.bits    = 4'h0;
        n.sda_rel = 1'b1;
        n.to      = '0;
      end else if (i_stop) begin
        n.st      = srap_pkg::I_IDLE;
        n.sda_rel = 1'b1;
      end else if (q.st != srap_pkg::I_IDLE) begin
        n.to = (f_nx[srap_pkg::I_SCL] & sda_now) ? '0 : q.to + 1'b1;
        if (q.to == TO_LAST) begin
          n.st      = srap_pkg::I_IDLE;
          n.sda_rel = 1'b1;
          n.to      = '0;
        end else begin
          unique case (q.st)
            srap_pkg::I_ADDR, srap_pkg::I_RX: begin
              if (scl_r) begin
                n.sh   = {q.sh[6:0], sda_now};
                n.bits = q.bits + 4'h1;
              end else if (scl_f && q.bits == srap_pkg::BYTE_BITS) begin
                n.bits    = 4'h0;
                n.sda_rel = 1'b0;
                n.st      = srap_pkg::I_ACK;
                if (q.st == srap_pkg::I_ADDR) begin
                  if (q.sh[7:1] != q.taddr) begin
                    // 10-bit and general call never match the strap address
                    n.st      = srap_pkg::I_IDLE;
                    n.sda_rel = 1'b1;
                  end else begin
                    n.rw   = q.sh[0];
                    n.ph   = srap_pkg::PH_PTR;
                    n.txlo = 1'b0;
                    n.rd   = q.sh[0];
                    n.addr = q.ptr;
                  end
                end else begin
                  unique case (q.ph)
                    srap_pkg::PH_PTR: begin
                      n.ptr = q.sh;
                      n.ph  = srap_pkg::PH_HI;
                    end
                    srap_pkg::PH_HI: begin
                      n.hibuf = q.sh;
                      n.ph    = srap_pkg::PH_LO;
                    end
                    default: begin
                      n.wr    = 1'b1;
                      n.addr  = q.ptr;
                      n.wdata = {q.hibuf, q.sh};
                      n.ph    = srap_pkg::PH_PTR;
                    end
                  endcase
                end
              end
            end
            srap_pkg::I_ACK: begin
              if (scl_f) begin
                n.bits = 4'h0;
                if (q.rw) begin
                  n.st      = srap_pkg::I_TX;
                  n.sh      = q.snap[15:8];
                  n.sda_rel = q.snap[15];
                  n.txlo    = 1'b0;
                end else begin
                  n.st      = srap_pkg::I_RX;
                  n.sda_rel = 1'b1;
                end
              end
            end
            srap_pkg::I_TX: begin
              if (scl_f) begin
                if (q.bits == srap_pkg::TX_LAST) begin
                  n.st      = srap_pkg::I_MACK;
                  n.sda_rel = 1'b1;
                  n.bits    = 4'h0;
                end else begin
                  n.sh      = {q.sh[6:0], 1'b0};
                  n.sda_rel = q.sh[6];
                  n.bits    = q.bits + 4'h1;
                end
              end
            end
            srap_pkg::I_MACK: begin
              if (scl_r) begin
                if (sda_now) begin
                  n.st = srap_pkg::I_IDLE;
                end else if (q.txlo) begin
                  // refetch before the next upper byte so each pair is coherent
                  n.rd   = 1'b1;
                  n.addr = q.ptr;
                end
              end else if (scl_f) begin
                n.st = srap_pkg::I_TX;
                if (q.txlo) begin
                  n.sh      = q.snap[15:8];
                  n.sda_rel = q.snap[15];
                  n.txlo    = 1'b0;
                end else begin
                  n.sh      = q.snap[7:0];
                  n.sda_rel = q.snap[7];
                  n.txlo    = 1'b1;
                end
              end
            end
            default: n.st = srap_pkg::I_IDLE;
          endcase
        end
      end
    end else begin
      if (cs_fall) begin
        // bits above the data read as zero; after a write they carry nothing
        n.sout = q.prev_rd ? {{(FW - DW){1'b0}}, q.snap} : '0;
      end else if (!q.f[srap_pkg::I_CS] && sclk_f) begin
        n.sin  = {q.sin[FW-2:0], f_nx[srap_pkg::I_SDI]};
        n.sout = {q.sout[FW-2:0], 1'b0};
      end
      if (cs_rise) begin
        n.addr    = {1'b0, q.sin[srap_pkg::ADR_HI:srap_pkg::ADR_LO]};
        n.wdata   = q.sin[DW-1:0];
        n.wr      = ~q.sin[srap_pkg::RW_BIT];
        n.rd      = q.sin[srap_pkg::RW_BIT];
        n.prev_rd = q.sin[srap_pkg::RW_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= Q_RST;
    end else begin
      q <= n;
    end
  end

  assign sda_out      = 1'b0;
  assign sda_oe_n     = q.sda_rel;
  assign spi_sdo      = q.sout[FW-1];
  assign spi_sdo_oe_n = ~ready | ~q.spi | q.f[srap_pkg::I_CS];
  assign reg_wr       = q.wr;
  assign reg_rd       = q.rd;
  assign reg_addr     = q.addr;
  assign reg_wdata    = q.wdata;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_lo_byte;
    q.st == srap_pkg::I_RX && q.ph == srap_pkg::PH_LO && scl_f
      && q.bits == srap_pkg::BYTE_BITS && !i_start && !i_stop && q.to != TO_LAST;
  endsequence
  sequence s_sclk_fall;
    ready && q.spi && !q.f[srap_pkg::I_CS] && sclk_f;
  endsequence
  sequence s_cs_rd;
    ready && q.spi && cs_rise && q.sin[srap_pkg::RW_BIT];
  endsequence

  property p_ptr_hold;
    $changed(q.ptr) |-> $past(q.st) == srap_pkg::I_RX && $past(q.ph) == srap_pkg::PH_PTR;
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved off a pointer byte");
  property p_wr_word;
    s_lo_byte |=> reg_wr && reg_wdata == {$past(q.hibuf), $past(q.sh)};
  endproperty
  a_wr_word: assert property (p_wr_word) else $error("word not committed on lower byte");
  property p_wr_ptr;
    reg_wr && !q.spi |-> q.ph == srap_pkg::PH_PTR && reg_addr == q.ptr;
  endproperty
  a_wr_ptr: assert property (p_wr_ptr) else $error("write not to pointer or phase wrong");
  property p_ack_drive;
    q.st == srap_pkg::I_ACK |-> !sda_oe_n;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack not driven low");
  property p_timeout;
    q.st != srap_pkg::I_IDLE && q.to == TO_LAST && !i_start && !i_stop
      |=> q.st == srap_pkg::I_IDLE && sda_oe_n;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not reset i2c");
  property p_nack;
    q.st == srap_pkg::I_MACK && scl_r && sda_now && !i_start && !i_stop && q.to != TO_LAST
      |=> q.st == srap_pkg::I_IDLE && sda_oe_n;
  endproperty
  a_nack: assert property (p_nack) else $error("sda held after nack");
  property p_cs_hiz;
    q.f[srap_pkg::I_CS] |-> spi_sdo_oe_n ##1 $stable(q.sin);
  endproperty
  a_cs_hiz: assert property (p_cs_hiz) else $error("sdo driven with cs high");
  property p_shift;
    s_sclk_fall |=> q.sin[0] == $past(f_nx[srap_pkg::I_SDI]);
  endproperty
  a_shift: assert property (p_shift) else $error("sdi bit not shifted in");
  property p_spi_wr;
    ready && q.spi && cs_rise && !q.sin[srap_pkg::RW_BIT]
      |=> reg_wr && reg_wdata == $past(q.sin[15:0]) && reg_addr[6:0] == $past(q.sin[22:16]);
  endproperty
  a_spi_wr: assert property (p_spi_wr) else $error("spi write frame not applied");
  property p_spi_rd;
    s_cs_rd |=> reg_rd ##2 q.snap == $past(reg_rdata);
  endproperty
  a_spi_rd: assert property (p_spi_rd) else $error("spi read data not captured");
endmodule : srap_top
`default_nettype wire

// ---- srap_host_model.sv ----
// Purpose: bus controller model driving the i2c and spi pins of srap_top
// Assumes: pins change 2 ns after a ref_clk rise
// Notes:   sda_drv low pulls the wire, high releases it to the pull-up
`timescale 1ns/10ps
`default_nettype none
module srap_host_model (
  input  wire logic ref_clk,
  input  wire logic sda_wire,
  input  wire logic spi_sdo,
  output logic      scl,
  output logic      sda_drv,
  output logic      spi_cs_n,
  output logic      spi_sclk,
  output logic      spi_sdi
);
  initial begin
    scl      = 1'b1;
    sda_drv  = 1'b1;
    spi_cs_n = 1'b1;
    spi_sclk = 1'b1;
    spi_sdi  = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : tick
  // scl period 575 ns keeps far above the bus timeout rate
  task automatic i2c_start;
    sda_drv = 1'b1;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_drv = 1'b0;
    tick(10);
    scl = 1'b0;
    tick(3);
  endtask : i2c_start
  task automatic i2c_stop;
    sda_drv = 1'b0;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_drv = 1'b1;
    tick(10);
  endtask : i2c_stop
  // releasing (1) a bit lets the target drive it, so reads reuse this
  task automatic i2c_byte(input logic [7:0] tx, input logic ack_in,
                          output logic [7:0] rx, output logic ack);
    logic [8:0] s;
    s = {tx, ack_in};
    for (int i = 8; i >= 0; i--) begin
      sda_drv = s[i];
      tick(10);
      scl = 1'b1;
      tick(10);
      if (i > 0) rx[i-1] = sda_wire;
      else ack = sda_wire;
      scl = 1'b0;
      // sda moves a little after scl falls so no false start or stop
      tick(3);
    end
  endtask : i2c_byte
  // gated 200 ns sclk, exactly 24 falls, cs raised after the last one
  task automatic spi_frame(input logic [23:0] tx, output logic [23:0] rx);
    spi_cs_n = 1'b0;
    tick(8);
    for (int i = 23; i >= 0; i--) begin
      spi_sdi = tx[i];
      tick(4);
      rx[i] = spi_sdo;
      spi_sclk = 1'b0;
      tick(4);
      spi_sclk = 1'b1;
    end
    tick(8);
    spi_cs_n = 1'b1;
    spi_sdi  = ~spi_sdi;
    tick(12);
  endtask : spi_frame
  task automatic spi_noise(input int n);
    for (int i = 0; i < n; i++) begin
      spi_sclk = ~spi_sclk;
      spi_sdi  = ~spi_sdi;
      tick(3);
    end
    spi_sclk = 1'b1;
  endtask : spi_noise
endmodule : srap_host_model
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: self-checking bench of srap_top in i2c mode, then spi mode
// Assumes: bench models the register bank, host model drives the pins
// Notes:   bus timeout shortened to TO cycles
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // a byte of zeros plus ack is about 9 scl periods; keep the limit far above that
  localparam int TO = 1000;
  localparam logic [6:0] ADDR_TAB [8] = '{7'h61, 7'h2c, 7'h64, 7'h2e,
                                          7'h62, 7'h2d, 7'h65, 7'h2f};
  logic        ref_clk   = 1'b0;
  logic        reset_n   = 1'b0;
  logic        if_sel    = 1'b0;
  logic [2:0]  straps    = 3'h0;
  logic [15:0] reg_rdata = 16'h0000;
  logic [15:0] mem [256];
  logic        sda_out, sda_oe_n, spi_sdo, spi_sdo_oe_n, reg_wr, reg_rd;
  logic        scl, sda_drv, spi_cs_n, spi_sclk, spi_sdi, rd_q, wr_q;
  logic [7:0]  reg_addr, a_q;
  logic [15:0] reg_wdata, d_q;
  logic [6:0]  ta;
  int          err_total    = 0;
  int          total_checks = 0;
  int          wr_cnt       = 0;
  int          cyc          = 0;
  int          seed         = 32'hcb4337de;
  wire         sda_wire = sda_drv & (sda_oe_n | sda_out);
  // released sdo shows the inverse so a stale value never passes
  wire         sdo_pin  = spi_sdo_oe_n ? ~spi_sdo : spi_sdo;
  always #12.5 ref_clk = ~ref_clk;
  srap_top #(.TIMEOUT_CYC(TO)) srap_top_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .if_sel_strap(if_sel),
    .target_addr_strap_0(straps[2]), .target_addr_strap_1(straps[1]),
    .target_addr_strap_2(straps[0]), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  srap_host_model srap_host_model_i (
    .ref_clk(ref_clk), .sda_wire(sda_wire), .spi_sdo(sdo_pin), .scl(scl),
    .sda_drv(sda_drv), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi));
  // bank: data only in the cycle after reg_rd, noise otherwise
  always @(posedge ref_clk) begin
    rd_q = reg_rd;
    wr_q = reg_wr;
    a_q  = reg_addr;
    d_q  = reg_wdata;
    #2;
    if (wr_q) begin
      mem[a_q] = d_q;
      wr_cnt++;
    end
    reg_rdata = rd_q ? mem[a_q] : 16'($random(seed));
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t bit got %b exp %b", $time, got, exp);
    end
  endtask : chk1
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk_cnt(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      err_total++;
      $display("ERROR t=%0t write count got %0d exp %0d", $time, got, exp);
    end
  endtask : chk_cnt
  task automatic st;
    srap_host_model_i.i2c_start();
  endtask : st
  task automatic sp;
    srap_host_model_i.i2c_stop();
  endtask : sp
  task automatic wb(input logic [7:0] tx, input logic exp_ack);
    logic [7:0] rx;
    logic       ack;
    srap_host_model_i.i2c_byte(tx, 1'b1, rx, ack);
    chk1(ack, exp_ack);
  endtask : wb
  task automatic rb(input logic mack, input logic [7:0] exp);
    logic [7:0] rx;
    logic       ack;
    srap_host_model_i.i2c_byte(8'hff, mack, rx, ack);
    chk8(rx, exp);
  endtask : rb
  task automatic sf(input logic [23:0] tx, output logic [23:0] rx);
    srap_host_model_i.spi_frame(tx, rx);
  endtask : sf
  task automatic do_reset(input logic sel);
    reset_n = 1'b0;
    if_sel  = sel;
    straps  = 3'($random(seed));
    repeat (2) @(posedge ref_clk);
    #2;
    reset_n = 1'b1;
    ta      = ADDR_TAB[straps];
    repeat (12) @(posedge ref_clk);
    #2;
  endtask : do_reset
  initial begin
    logic [7:0]  p1, p2, p3, p4;
    logic [15:0] d1, d2, d3, nv;
    logic [23:0] rx;
    logic [6:0]  a7, prev;
    int          n0;
    for (int i = 0; i < 256; i++) mem[i] = 16'($random(seed));
    do_reset(1'b0);
    p1 = 8'($random(seed));
    p2 = p1 ^ 8'h40;
    p3 = p2 ^ 8'h80;
    p4 = p1 ^ 8'h01;
    d1 = 16'($random(seed));
    d2 = 16'($random(seed));
    d3 = 16'($random(seed)) & 16'h7fff;
    nv = mem[p4];
    for (int k = 0; k < 3; k++) begin
      st();
      wb(k == 0 ? {ta ^ 7'h10, 1'b0} : (k == 1 ? 8'h00 : 8'hf0), 1'b1);
      sp();
    end
    n0 = wr_cnt;
    st();
    wb({ta, 1'b0}, 1'b0);
    wb(p1, 1'b0);
    wb(d1[15:8], 1'b0);
    chk_cnt(wr_cnt, n0);
    wb(d1[7:0], 1'b0);
    sp();
    chk16(mem[p1], d1);
    chk_cnt(wr_cnt, n0 + 1);
    st();
    wb({ta, 1'b0}, 1'b0);
    for (int k = 0; k < 2; k++) begin
      wb(k == 0 ? p2 : p3, 1'b0);
      wb(k == 0 ? d2[15:8] : d3[15:8], 1'b0);
      wb(k == 0 ? d2[7:0] : d3[7:0], 1'b0);
    end
    sp();
    chk16(mem[p2], d2);
    chk16(mem[p3], d3);
    st();
    wb({ta, 1'b0}, 1'b0);
    wb(p4, 1'b0);
    wb(8'h5a, 1'b0);
    sp();
    chk16(mem[p4], nv);
    st();
    wb({ta, 1'b0}, 1'b0);
    wb(p1, 1'b0);
    sp();
    chk_cnt(wr_cnt, n0 + 3);
    nv = 16'($random(seed));
    st();
    wb({ta, 1'b1}, 1'b0);
    rb(1'b0, d1[15:8]);
    mem[p1] = nv;
    rb(1'b0, d1[7:0]);
    rb(1'b0, nv[15:8]);
    rb(1'b1, nv[7:0]);
    sp();
    chk1(sda_oe_n, 1'b1);
    st();
    wb({ta, 1'b0}, 1'b0);
    wb(p3, 1'b0);
    st();
    wb({ta, 1'b1}, 1'b0);
    rb(1'b0, d3[15:8]);
    rb(1'b1, d3[7:0]);
    sp();
    // top bit of d3 is 0, so the target is pulling sda during the stall
    st();
    wb({ta, 1'b1}, 1'b0);
    // wait past the ack so the pull seen is the first data bit
    srap_host_model_i.tick(4);
    chk1(sda_oe_n, 1'b0);
    srap_host_model_i.tick(TO + 100);
    chk1(sda_oe_n, 1'b1);
    rb(1'b1, 8'hff);
    sp();
    st();
    wb({ta, 1'b0}, 1'b0);
    sp();
    sf({1'b0, 7'h11, 16'hbeef}, rx);
    chk_cnt(wr_cnt, n0 + 3);
    do_reset(1'b1);
    st();
    wb({ta, 1'b0}, 1'b1);
    sp();
    srap_host_model_i.spi_noise(40);
    chk_cnt(wr_cnt, n0 + 3);
    chk1(spi_sdo_oe_n, 1'b1);
    for (int k = 0; k < 4; k++) begin
      a7 = k == 0 ? 7'h7f : (k == 1 ? 7'h00 : 7'($random(seed)));
      d1 = 16'($random(seed));
      sf({1'b0, a7, d1}, rx);
      chk16(mem[{1'b0, a7}], d1);
    end
    chk_cnt(wr_cnt, n0 + 7);
    chk8(reg_addr, {1'b0, a7});
    prev = 7'($random(seed));
    sf({1'b1, prev, 16'h0000}, rx);
    for (int k = 0; k < 4; k++) begin
      a7 = 7'($random(seed));
      sf({1'b1, a7, 16'($random(seed))}, rx);
      chk16(rx[15:0], mem[{1'b0, prev}]);
      prev = a7;
    end
    chk_cnt(wr_cnt, n0 + 7);
    chk1(spi_sdo_oe_n, 1'b1);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
